//--- src/swr_regs.svh
// Register map, field positions, reset values and command codes of the switch register bank
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

`define SWR_ADDR_SWITCH 7'h01
`define SWR_ADDR_CFG 7'h02
`define SWR_ADDR_FLAGS 7'h03
`define SWR_ADDR_BURST 7'h05
`define SWR_ADDR_KEY 7'h0B

`define SWR_RST_SWITCH 4'h0
`define SWR_RST_CFG 3'h6
`define SWR_RST_FLAGS 3'h0
`define SWR_RST_BURST 1'h0
`define SWR_RST_KEY 8'h00

`define SWR_CFG_ADDR_BIT 2
`define SWR_CFG_SCLK_BIT 1
`define SWR_CFG_CRC_BIT 0
`define SWR_FLAG_ADDR_BIT 2
`define SWR_FLAG_SCLK_BIT 1
`define SWR_FLAG_CRC_BIT 0
`define SWR_BURST_BIT 0
`define SWR_READ_BIT 7

`define SWR_KEY_FIRST 8'hA3
`define SWR_KEY_SECOND 8'h05
`define SWR_CLEAR_CMD 16'h6CA9
`define SWR_CRC_POLY 8'h07
`define SWR_IDX_LAST_PLAIN 2'h1
`define SWR_IDX_LAST_CRC 2'h2

`endif

//--- src/swr_pkg.sv
// Types shared by the switch register bank modules
package swr_pkg;
	typedef logic [7:0] swr_byte_t;
	typedef enum logic [4:0] {
		CK_WRITE = 5'h01,
		CK_READ = 5'h02,
		CK_CLEAR = 5'h04,
		CK_BADADDR = 5'h08,
		CK_BADCRC = 5'h10
	} swr_kind_e;
endpackage

//--- src/swr_link_if.sv
// Carrier between the serial-clock shifter and the core-clock register bank
`timescale 1ns/100ps
`default_nettype none
interface swr_link_if;
	import swr_pkg::*;
	swr_byte_t byte_data;
	logic byte_tog;
	logic [2:0] resid;
	swr_byte_t tx_word;
	modport link(output byte_data, output byte_tog, output resid, input tx_word);
	modport core(input byte_data, input byte_tog, input resid, output tx_word);
endinterface
`default_nettype wire

//--- src/swr_link_shift.sv
// Serial-clock domain shifter: frames bytes in, shifts read data out
`timescale 1ns/100ps
`default_nettype none
module swr_link_shift
	import swr_pkg::*;
(
	// Link pins
	input wire logic sclk_i,
	input wire logic cs_b_i,
	input wire logic sdi_i,
	input wire logic rst_b_i,
	output logic sdo_o,
	// Core side
	swr_link_if.link lk
);
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;
	swr_byte_t tx_reg;
	logic frame_rst_b;

	// Chip select high restarts the bit position so bytes align to the frame
	assign frame_rst_b = rst_b_i & ~cs_b_i;

	// Bit position within the current byte
	always_ff @(posedge sclk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			bit_cnt_reg <= 3'h0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// Receive shift, sampled on the rising edge
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_reg <= 7'h00;
		end else begin
			shift_reg <= {shift_reg[5:0], sdi_i};
		end
	end

	// Byte handoff; the word holds for eight edges while the toggle crosses
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lk.byte_data <= 8'h00;
			lk.byte_tog <= 1'b0;
			lk.resid <= 3'h0;
		end else begin
			lk.resid <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				lk.byte_data <= {shift_reg, sdi_i};
				lk.byte_tog <= ~lk.byte_tog;
			end
		end
	end

	// Transmit shift; first byte of a frame is zero, later bytes carry read data
	always_ff @(posedge sclk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			tx_reg <= 8'h00;
		end else if (bit_cnt_reg == 3'h7) begin
			tx_reg <= lk.tx_word;
		end else begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// Data leaves on the falling edge for mode 0 and mode 3 hosts
	always_ff @(negedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sdo_o <= 1'b0;
		end else begin
			sdo_o <= tx_reg[7];
		end
	end
endmodule
`default_nettype wire

//--- src/swr_bank.sv
// Switch register bank behind a serial link, core-clock side
`timescale 1ns/100ps
`default_nettype none
`include "swr_regs.svh"
module swr_bank
	import swr_pkg::*;
(
	// Core clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Serial link pins
	input wire logic SCLK_I,
	input wire logic CS_B_I,
	input wire logic SDI_I,
	output logic SDO_O,
	// Switch drives
	output logic [3:0] SW_CLOSE_O
);
	swr_link_if lk_if();

	logic [3:0] switch_reg;
	logic [2:0] cfg_reg;
	logic [2:0] flags_reg;
	logic burst_reg;
	swr_byte_t key_reg;
	logic key_armed_reg;
	swr_byte_t rd_byte_reg;
	logic [2:0] cs_sync_reg;
	logic [2:0] tog_sync_reg;
	logic frame_end_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] frame_bytes_reg;
	swr_byte_t hi_reg;
	swr_byte_t lo_reg;
	logic pend_valid_reg;
	swr_byte_t pend_hi_reg;
	swr_byte_t pend_lo_reg;
	logic pend_crc_ok_reg;
	logic exec_stb_reg;
	swr_byte_t exec_hi_reg;
	swr_byte_t exec_lo_reg;
	logic exec_crc_ok_reg;

	logic byte_evt;
	logic cs_rise;
	logic crc_on;
	logic sclk_on;
	logic addr_on;
	logic [1:0] last_idx;
	logic cmd_done;
	swr_byte_t cmd_lo;
	logic cmd_crc_ok;
	logic len_ok;
	swr_kind_e kind;
	logic wr_switch;
	logic wr_cfg;
	logic wr_burst;
	logic wr_key;
	logic soft_rst;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	swr_byte_t rd_value;

	// Serial checksum over the command word, most significant bit first
	function automatic swr_byte_t crc8(input logic [15:0] d);
		swr_byte_t c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ `SWR_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// Address map; the flag register answers reads only
	function automatic logic addr_known(input logic [6:0] a, input logic rd);
		case (a)
			`SWR_ADDR_SWITCH, `SWR_ADDR_CFG, `SWR_ADDR_BURST, `SWR_ADDR_KEY: return 1'b1;
			`SWR_ADDR_FLAGS: return rd;
			default: return 1'b0;
		endcase
	endfunction

	// Classify a finished command
	function automatic swr_kind_e cmd_kind(input swr_byte_t hi, input swr_byte_t lo,
			input logic crc_ok);
		if (!crc_ok) begin
			return CK_BADCRC;
		end
		// clear command exempt from address check
		if ({hi, lo} == `SWR_CLEAR_CMD) begin
			return CK_CLEAR;
		end
		if (hi[`SWR_READ_BIT]) begin
			return addr_known(hi[6:0], 1'b1) ? CK_READ : CK_BADADDR;
		end
		return addr_known(hi[6:0], 1'b0) ? CK_WRITE : CK_BADADDR;
	endfunction

	// Synchronisers: two flops before use, the third is edge history only
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cs_sync_reg <= 3'h7;
			tog_sync_reg <= 3'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], CS_B_I};
			tog_sync_reg <= {tog_sync_reg[1:0], lk_if.byte_tog};
		end
	end

	// Frame end waits one cycle so a last byte crossing together is counted
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			frame_end_reg <= 1'b0;
		end else begin
			frame_end_reg <= cs_rise;
		end
	end

	// Frame decode and frame-length judgement
	always_comb begin
		byte_evt = tog_sync_reg[1] ^ tog_sync_reg[2];
		cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
		crc_on = cfg_reg[`SWR_CFG_CRC_BIT];
		sclk_on = cfg_reg[`SWR_CFG_SCLK_BIT];
		addr_on = cfg_reg[`SWR_CFG_ADDR_BIT];
		// checksum byte lengthens each command to 24 bits
		last_idx = crc_on ? `SWR_IDX_LAST_CRC : `SWR_IDX_LAST_PLAIN;
		cmd_done = byte_evt && (byte_idx_reg == last_idx);
		cmd_lo = crc_on ? lo_reg : lk_if.byte_data;
		cmd_crc_ok = !crc_on || (crc8({hi_reg, lo_reg}) == lk_if.byte_data);
		if (lk_if.resid != 3'h0) begin
			len_ok = 1'b0;
		end else if (burst_reg) begin
			len_ok = (byte_idx_reg == 2'h0) && (frame_bytes_reg != 8'h00);
		end else begin
			len_ok = frame_bytes_reg == {6'h00, last_idx + 2'h1};
		end
	end

	// Byte assembly into commands; the remainder count stays still after the frame
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			byte_idx_reg <= 2'h0;
			frame_bytes_reg <= 8'h00;
			hi_reg <= 8'h00;
			lo_reg <= 8'h00;
		end else if (frame_end_reg) begin
			byte_idx_reg <= 2'h0;
			frame_bytes_reg <= 8'h00;
		end else if (byte_evt) begin
			if (frame_bytes_reg != 8'hFF) begin
				frame_bytes_reg <= frame_bytes_reg + 8'h01;
			end
			case (byte_idx_reg)
				2'h0: hi_reg <= lk_if.byte_data;
				2'h1: lo_reg <= lk_if.byte_data;
				default: ;
			endcase
			byte_idx_reg <= cmd_done ? 2'h0 : byte_idx_reg + 2'h1;
		end
	end

	// Single-command frames wait for chip select so a bad length can veto them
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pend_valid_reg <= 1'b0;
			pend_hi_reg <= 8'h00;
			pend_lo_reg <= 8'h00;
			pend_crc_ok_reg <= 1'b0;
		end else if (frame_end_reg) begin
			pend_valid_reg <= 1'b0;
		end else if (cmd_done && !burst_reg && !pend_valid_reg) begin
			pend_valid_reg <= 1'b1;
			pend_hi_reg <= hi_reg;
			pend_lo_reg <= cmd_lo;
			pend_crc_ok_reg <= cmd_crc_ok;
		end
	end

	// Execution strobe
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			exec_stb_reg <= 1'b0;
			exec_hi_reg <= 8'h00;
			exec_lo_reg <= 8'h00;
			exec_crc_ok_reg <= 1'b0;
		end else begin
			exec_stb_reg <= 1'b0;
			// a disabled count check rejects nothing
			if (frame_end_reg && !burst_reg && pend_valid_reg && (len_ok || !sclk_on)) begin
				exec_stb_reg <= 1'b1;
				exec_hi_reg <= pend_hi_reg;
				exec_lo_reg <= pend_lo_reg;
				exec_crc_ok_reg <= pend_crc_ok_reg;
			end else if (cmd_done && burst_reg) begin
				// burst runs each command as it completes
				exec_stb_reg <= 1'b1;
				exec_hi_reg <= hi_reg;
				exec_lo_reg <= cmd_lo;
				exec_crc_ok_reg <= cmd_crc_ok;
			end
		end
	end

	// Command effects
	always_comb begin
		kind = cmd_kind(exec_hi_reg, exec_lo_reg, exec_crc_ok_reg);
		wr_switch = 1'b0;
		wr_cfg = 1'b0;
		wr_burst = 1'b0;
		wr_key = 1'b0;
		flag_set = 3'h0;
		flag_clr = 3'h0;
		if (exec_stb_reg) begin
			case (kind)
				CK_WRITE: begin
					wr_switch = exec_hi_reg[6:0] == `SWR_ADDR_SWITCH;
					wr_cfg = exec_hi_reg[6:0] == `SWR_ADDR_CFG;
					wr_burst = exec_hi_reg[6:0] == `SWR_ADDR_BURST;
					wr_key = exec_hi_reg[6:0] == `SWR_ADDR_KEY;
				end
				CK_CLEAR: flag_clr = 3'h7;
				CK_BADADDR: flag_set[`SWR_FLAG_ADDR_BIT] = addr_on;
				CK_BADCRC: flag_set[`SWR_FLAG_CRC_BIT] = 1'b1;
				default: ;
			endcase
		end
		if (frame_end_reg && sclk_on && !len_ok) begin
			flag_set[`SWR_FLAG_SCLK_BIT] = 1'b1;
		end
		soft_rst = wr_key && key_armed_reg && (exec_lo_reg == `SWR_KEY_SECOND);
	end

	// Writable registers; reserved bits never stored
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			switch_reg <= `SWR_RST_SWITCH;
			cfg_reg <= `SWR_RST_CFG;
			burst_reg <= `SWR_RST_BURST;
			key_reg <= `SWR_RST_KEY;
		end else if (soft_rst) begin
			switch_reg <= `SWR_RST_SWITCH;
			cfg_reg <= `SWR_RST_CFG;
			burst_reg <= `SWR_RST_BURST;
			key_reg <= `SWR_RST_KEY;
		end else begin
			if (wr_switch) begin
				switch_reg <= exec_lo_reg[3:0];
			end
			if (wr_cfg) begin
				cfg_reg <= exec_lo_reg[2:0];
			end
			if (wr_burst) begin
				burst_reg <= exec_lo_reg[`SWR_BURST_BIT];
			end
			if (wr_key) begin
				key_reg <= exec_lo_reg;
			end
		end
	end

	// Key sequence: any other command between the two values disarms it
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			key_armed_reg <= 1'b0;
		end else if (exec_stb_reg) begin
			key_armed_reg <= wr_key && !soft_rst && (exec_lo_reg == `SWR_KEY_FIRST);
		end
	end

	// sticky error flags, a set beats a clear in the same cycle
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			flags_reg <= `SWR_RST_FLAGS;
		end else if (soft_rst) begin
			flags_reg <= `SWR_RST_FLAGS | flag_set;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
		end
	end

	always_comb begin
		case (exec_hi_reg[6:0])
			`SWR_ADDR_SWITCH: rd_value = {4'h0, switch_reg};
			`SWR_ADDR_CFG: rd_value = {5'h00, cfg_reg};
			`SWR_ADDR_FLAGS: rd_value = {5'h00, flags_reg};
			`SWR_ADDR_BURST: rd_value = {7'h00, burst_reg};
			`SWR_ADDR_KEY: rd_value = key_reg;
			default: rd_value = 8'h00;
		endcase
	end

	// Read data of a single-command frame waits for the next frame; the shifter takes it at a byte edge
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rd_byte_reg <= 8'h00;
		end else if (exec_stb_reg && (kind == CK_READ)) begin
			rd_byte_reg <= rd_value;
		end else if (exec_stb_reg && (kind == CK_BADADDR) && exec_hi_reg[`SWR_READ_BIT]) begin
			rd_byte_reg <= 8'h00;
		end
	end

	assign lk_if.tx_word = rd_byte_reg;
	// switch drives straight from the register
	assign SW_CLOSE_O = switch_reg;

	// Serial-clock side
	swr_link_shift u_link (
		.sclk_i(SCLK_I),
		.cs_b_i(CS_B_I),
		.sdi_i(SDI_I),
		.rst_b_i(RST_B_I),
		.sdo_o(SDO_O),
		.lk(lk_if.link)
	);

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_B_I);

	sequence s_exec(swr_kind_e k);
		exec_stb_reg && (kind == k);
	endsequence

	sequence s_wr_to(logic [6:0] a);
		s_exec(CK_WRITE) ##0 (exec_hi_reg[6:0] == a);
	endsequence

	sequence s_key(swr_byte_t v);
		s_wr_to(`SWR_ADDR_KEY) ##0 (exec_lo_reg == v);
	endsequence

	sequence s_frame_end_bad;
		frame_end_reg && sclk_on && !len_ok;
	endsequence

	a_switch_write: assert property (
		s_wr_to(`SWR_ADDR_SWITCH) ##0 !soft_rst |=> SW_CLOSE_O == $past(exec_lo_reg[3:0])
	) else $error("switch write not applied");

	a_reserved_zero: assert property (
		s_exec(CK_READ) ##0 (exec_hi_reg[6:0] == `SWR_ADDR_SWITCH) |=> rd_byte_reg[7:4] == 4'h0
	) else $error("reserved switch bits read nonzero");

	a_cfg_reset: assert property (
		$rose(RST_B_I) |-> cfg_reg == `SWR_RST_CFG && switch_reg == `SWR_RST_SWITCH
	) else $error("enable register not at reset value");

	a_addr_err_set: assert property (
		s_exec(CK_BADADDR) ##0 addr_on |=> flags_reg[`SWR_FLAG_ADDR_BIT]
	) else $error("invalid address not flagged");

	a_len_plain: assert property (
		s_frame_end_bad ##0 !crc_on && !burst_reg |=> flags_reg[`SWR_FLAG_SCLK_BIT] ##1
			!exec_stb_reg
	) else $error("bad 16-clock frame not flagged or executed");

	a_len_crc: assert property (
		frame_end_reg && sclk_on && crc_on && !burst_reg && pend_valid_reg &&
			(frame_bytes_reg != 8'h03) |=> !exec_stb_reg && flags_reg[`SWR_FLAG_SCLK_BIT]
	) else $error("bad 24-clock frame accepted");

	a_len_burst: assert property (
		frame_end_reg && sclk_on && burst_reg && (byte_idx_reg != 2'h0) |=>
			flags_reg[`SWR_FLAG_SCLK_BIT]
	) else $error("partial burst command not flagged");

	a_crc_reject: assert property (
		s_exec(CK_BADCRC) |=> flags_reg[`SWR_FLAG_CRC_BIT] && $stable(switch_reg)
	) else $error("bad checksum not rejected");

	a_clear_flags: assert property (
		s_exec(CK_CLEAR) ##0 !frame_end_reg |=> flags_reg == 3'h0
	) else $error("clear command left a flag");

	a_burst_enable: assert property (
		s_wr_to(`SWR_ADDR_BURST) ##0 !soft_rst |=> burst_reg == $past(exec_lo_reg[0])
	) else $error("burst enable not written");

	a_key_arm: assert property (
		s_key(`SWR_KEY_FIRST) |=> key_armed_reg
	) else $error("first key value did not arm");

	a_soft_reset: assert property (
		key_armed_reg ##0 s_key(`SWR_KEY_SECOND) |=> cfg_reg == `SWR_RST_CFG &&
			switch_reg == `SWR_RST_SWITCH && !burst_reg && !key_armed_reg
	) else $error("software reset did not restore defaults");

	a_flag_gated: assert property (
		1'b1 |=> (flags_reg & ~$past(flags_reg) & ~$past(cfg_reg)) == 3'h0
	) else $error("flag raised by disabled check");

endmodule
`default_nettype wire

//--- verif/swr_host_model.sv
// Serial host model: chip select, mode-0 serial clock, data and CRC byte
`timescale 1ns/100ps
`default_nettype none
`include "swr_regs.svh"
module swr_host_model (
	// Link pins toward the bank
	output logic sclk_o,
	output logic cs_b_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// Clock stands still and chip select idles high outside frames
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		sdi_o = 1'b1;
	end

	// CRC-8 over both command bytes, MSB first, zero start
	function automatic logic [7:0] crc8(input logic [15:0] c);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ c[i]) ? `SWR_CRC_POLY : 8'h00);
		end
		return r;
	endfunction

	// One frame of n clocks from the top of w; slow idles the clock low after each bit
	task automatic frame(input logic [47:0] w, input int n, input int slow,
		output logic [7:0] rd);
		rd = 8'h00;
		cs_b_o = 1'b0;
		#30;
		for (int i = 0; i < n; i++) begin
			sdi_o = w[47 - i];
			#24;
			if (i >= 8 && i < 16) begin
				rd = {rd[6:0], sdo_i};
			end
			sclk_o = 1'b1;
			#24;
			sclk_o = 1'b0;
			#(slow);
		end
		#24;
		cs_b_o = 1'b1;
		// Released data line shows the inverse, never a stale bit
		sdi_o = ~sdi_o;
		#300;
	endtask

	// One command; bad flips the low bit of the check byte on purpose
	// With crc set a CRC byte is appended for 24-bit frames, else 16-bit frames
	task automatic cmd(input logic [15:0] c, input logic crc, input logic bad, input int slow,
		output logic [7:0] rd);
		if (crc) begin
			frame({c, crc8(c) ^ {7'h00, bad}, 24'h0}, 24, slow, rd);
		end else begin
			frame({c, 32'h0}, 16, slow, rd);
		end
	endtask
endmodule
`default_nettype wire

//--- verif/test_swr_bank.sv
// Self-checking bench for the switch register bank
`timescale 1ns/100ps
`default_nettype none
`include "swr_regs.svh"
`define CHK(nm, ex, got) begin \
	n_checks++; \
	if ((got) !== (ex)) begin \
		n_fail++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); \
	end \
end
module test_swr_bank;
	import swr_pkg::*;
	logic clock_i;
	logic rst_b_i;
	logic sclk;
	logic cs_b;
	logic sdi;
	logic sdo;
	logic [3:0] sw_close;
	logic crc;
	logic burst;
	logic [7:0] d;
	logic [7:0] v;
	int n_fail;
	int n_checks;
	integer seed;
	int cyc = 0;
	logic [6:0] addrs [5] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h0B};
	logic [7:0] rstv [5] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
	int lens [3] = '{15, 17, 32};

	swr_bank swr_bank_inst (
		.CLOCK_I(clock_i),
		.RST_B_I(rst_b_i),
		.SCLK_I(sclk),
		.CS_B_I(cs_b),
		.SDI_I(sdi),
		.SDO_O(sdo),
		.SW_CLOSE_O(sw_close)
	);

	swr_host_model swr_host_model_inst (
		.sclk_o(sclk),
		.cs_b_o(cs_b),
		.sdi_o(sdi),
		.sdo_i(sdo)
	);

	// Core clock, 20 ns
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// Frame length accepted for the present CRC and burst settings
	function automatic logic cnt_ok(input int n);
		int u;
		u = crc ? 24 : 16;
		return (n % u == 0) && (burst || n == u);
	endfunction

	// Register write at a random bit pace
	task automatic wr(input logic [6:0] a, input logic [7:0] x);
		logic [7:0] r;
		swr_host_model_inst.cmd({1'b0, a, x}, crc, 1'b0, {$random(seed)} % 64, r);
	endtask

	// Read data arrives in the frame after the request
	task automatic rd(input logic [6:0] a, output logic [7:0] x);
		swr_host_model_inst.cmd({1'b1, a, 8'h00}, crc, 1'b0, {$random(seed)} % 64, x);
		swr_host_model_inst.cmd({1'b1, 7'h01, 8'h00}, crc, 1'b0, 0, x);
	endtask

	// Flag clearing command
	task automatic clr();
		logic [7:0] r;
		swr_host_model_inst.cmd(`SWR_CLEAR_CMD, crc, 1'b0, 0, r);
	endtask

	task automatic finish_test();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Cycle ceiling cuts a hang short
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		seed = 32'h91ad6a44;
		n_fail = 0;
		n_checks = 0;
		crc = 1'b0;
		burst = 1'b0;
		rst_b_i = 1'b0;
		repeat (4) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		// Reset values of every mapped register
		`CHK("switch drive", 4'h0, sw_close)
		for (int i = 0; i < 5; i++) begin
			rd(addrs[i], d);
			`CHK("reset value", rstv[i], d)
		end
		// Random switch patterns, reserved bits written as zero
		repeat (6) begin
			v = $random(seed);
			wr(7'h01, {4'h0, v[3:0]});
			`CHK("switch drive", v[3:0], sw_close)
			rd(7'h01, d);
			`CHK("switch reg", {4'h0, v[3:0]}, d)
		end
		// Wrong frame lengths refused and flagged
		wr(7'h01, 8'h00);
		foreach (lens[i]) begin
			swr_host_model_inst.frame({16'h010F, 32'h0}, lens[i], 0, d);
			rd(7'h03, d);
			`CHK("count flag", cnt_ok(lens[i]) ? 8'h00 : 8'h02, d)
			`CHK("switch drive", 4'h0, sw_close)
			clr();
		end
		rd(7'h03, d);
		`CHK("cleared flags", 8'h00, d)
		// Unmapped and read-only targets
		wr(7'h04, 8'h55);
		rd(7'h03, d);
		`CHK("address flag", 8'h04, d)
		clr();
		wr(7'h03, 8'h00);
		rd(7'h03, d);
		`CHK("read-only flag", 8'h04, d)
		clr();
		// All checks off: nothing flagged, first command of a long frame runs
		wr(7'h02, 8'h00);
		wr(7'h04, 8'h55);
		swr_host_model_inst.frame({16'h0103, 16'h0105, 16'h0}, 32, 0, d);
		`CHK("first command only", 4'h3, sw_close)
		rd(7'h03, d);
		`CHK("disabled flags", 8'h00, d)
		// CRC on: good frame runs, bad check byte and short frame refused
		wr(7'h02, 8'h07);
		crc = 1'b1;
		wr(7'h01, 8'h09);
		`CHK("crc write", 4'h9, sw_close)
		swr_host_model_inst.cmd(16'h0106, 1'b1, 1'b1, 0, d);
		swr_host_model_inst.frame({16'h0106, 32'h0}, 16, 0, d);
		`CHK("refused writes", 4'h9, sw_close)
		rd(7'h03, d);
		`CHK("crc and count flags", 8'h03, d)
		clr();
		rd(7'h03, d);
		`CHK("crc clear", 8'h00, d)
		// Burst with CRC: whole commands run, a partial one flags
		wr(7'h05, 8'h01);
		burst = 1'b1;
		swr_host_model_inst.frame({16'h0102, swr_host_model_inst.crc8(16'h0102), 16'h010C,
			swr_host_model_inst.crc8(16'h010C)}, 48, 0, d);
		`CHK("burst crc", 4'hC, sw_close)
		swr_host_model_inst.frame({16'h0102, swr_host_model_inst.crc8(16'h0102), 24'h0},
			40, 0, d);
		rd(7'h03, d);
		`CHK("burst crc count", cnt_ok(40) ? 8'h00 : 8'h02, d)
		clr();
		// Burst without CRC
		wr(7'h02, 8'h06);
		crc = 1'b0;
		swr_host_model_inst.frame({16'h010A, 16'h0105, 16'h0}, 32, 20, d);
		`CHK("burst plain", 4'h5, sw_close)
		swr_host_model_inst.frame({16'h010A, 32'h0}, 24, 0, d);
		rd(7'h03, d);
		`CHK("burst count flag", cnt_ok(24) ? 8'h00 : 8'h02, d)
		rd(7'h05, d);
		`CHK("burst reg", 8'h01, d)
		// key bytes in consecutive commands restore defaults
		wr(`SWR_ADDR_KEY, `SWR_KEY_FIRST);
		wr(`SWR_ADDR_KEY, `SWR_KEY_SECOND);
		burst = 1'b0;
		`CHK("soft reset drive", 4'h0, sw_close)
		for (int i = 0; i < 5; i++) begin
			rd(addrs[i], d);
			`CHK("soft reset value", rstv[i], d)
		end
		finish_test();
	end
endmodule
`default_nettype wire
